// ### rtl/txirq_detect.sv
`timescale 1ns/1ps
module txirq_detect
    import txirq_pkg::*;
(
    // Clock and control.
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Source and mode.
    input  wire logic        cond_i,
    input  wire txirq_trig_e trig_i,
    // Detection result.
    output logic             hit_o
);

    typedef struct packed {
        logic prev;
    } txirq_det_s;

    txirq_det_s st;
    txirq_det_s next_st;

    always_comb begin
        next_st      = st;
        next_st.prev = cond_i;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign hit_o = txirq_fires(trig_i, st.prev, cond_i);

    chk_rsvd_silent: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        trig_i == TRIG_RSVD |-> !hit_o)
        else $error("reserved trigger mode produced a hit");
    chk_fall_polarity: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        (trig_i == TRIG_FALL && hit_o) |-> (!cond_i && st.prev))
        else $error("falling mode hit while source high");

endmodule // txirq_detect

// ### rtl/txirq_pkg.sv
package txirq_pkg;

    // Register offsets on the internal register port.
    localparam logic [7:0] TXIRQ_STATUS_ADDR   = 8'h0a;
    localparam logic [7:0] TXIRQ_ENABLE_ADDR   = 8'h0b;
    localparam logic [7:0] TXIRQ_TRIGGER_ADDR  = 8'h0c;

    // Field positions.
    localparam int TXIRQ_XFER_EN_BIT   = 0;
    localparam int TXIRQ_SLIP_EN_BIT   = 1;
    localparam int TXIRQ_XFER_TRIG_LSB = 0;
    localparam int TXIRQ_SLIP_TRIG_LSB = 2;
    localparam int TXIRQ_XFER_FLAG_BIT = 0;
    localparam int TXIRQ_SLIP_FLAG_BIT = 1;

    // Values after reset.
    localparam logic [1:0] TXIRQ_ENABLE_RST  = 2'h0;
    localparam logic [1:0] TXIRQ_TRIGGER_RST = 2'h0;

    typedef enum logic [1:0] {
        TRIG_RISE  = 2'b00,
        TRIG_FALL  = 2'b01,
        TRIG_LEVEL = 2'b10,
        TRIG_RSVD  = 2'b11
    } txirq_trig_e;

    // Decides whether a source fires this cycle for a given trigger mode.
    function automatic logic txirq_fires(input txirq_trig_e mode,
                                         input logic        prev,
                                         input logic        cond);
        logic f;
        f = 1'b0;
        case (mode)
            TRIG_RISE:  f = cond & ~prev;
            TRIG_FALL:  f = ~cond & prev;
            TRIG_LEVEL: f = cond;
            default:    f = 1'b0;
        endcase
        return f;
    endfunction

endpackage

// ### rtl/txirq_top.sv
// Functional notes
// - Transfer enable resets to 0; 0 blocks the copy source, 1 passes it.
// - Slip enable resets to 0; 0 blocks the slip source, 1 passes it.
// - Enable register at 0x0b: slip in bit 1, transfer in bit 0, 7:2 zero.
// - Transfer mode: 00 rising (reset), 01 falling, 10 level, 11 reserved.
// - Slip mode: 00 rising (reset), 01 falling, 10 level, 11 reserved.
// - Mode register at 0x0c: slip in bits 3:2, transfer in 1:0, 7:4 zero.
// - A finished copy, if enabled and copies are on, sets its flag, irq low and summary high.
// - With slip enabled, a slip or block start (by select) sets the flag.
`timescale 1ns/1ps
module txirq_top
    import txirq_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Register port.
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // Event sources.
    input  wire logic       xfer_complete_event_i,
    input  wire logic       transmit_copy_disable_i,
    input  wire logic       async_slip_i,
    input  wire logic       block_start_i,
    input  wire logic       slip_source_select_i,
    // Interrupt and status.
    output logic            irq_n_o,
    output logic            tx_summary_o,
    output logic            xfer_done_flag_o,
    output logic            slip_flag_o
);

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic        xfer_done_irq_enable;
        logic        slip_irq_enable;
        txirq_trig_e xfer_done_irq_trigger;
        txirq_trig_e slip_irq_trigger;
        logic        xfer_done_flag;
        logic        slip_flag;
        logic        irq_n;
        logic        summary;
        logic [7:0]  rdata;
    } txirq_top_s;

    txirq_top_s st;
    txirq_top_s next_st;

    logic xfer_cond;
    logic slip_cond;
    logic xfer_hit;
    logic slip_hit;
    logic xfer_raw;
    logic status_rd;

    // The copy gate sits behind the detector: switching copies off while a
    // copy is pending must not be taken for a falling edge of the source.
    assign xfer_cond = xfer_complete_event_i & ~transmit_copy_disable_i;
    assign xfer_hit  = xfer_raw & ~transmit_copy_disable_i;
    assign slip_cond = slip_source_select_i ? block_start_i
                                            : async_slip_i;
    assign status_rd = reg_rd_i && (reg_addr_i == TXIRQ_STATUS_ADDR);

    ////////////////////////////////////////////////////////////////////////

    txirq_detect u_xfer_det (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .cond_i (xfer_complete_event_i),
        .trig_i (st.xfer_done_irq_trigger),
        .hit_o  (xfer_raw)
    );

    txirq_detect u_slip_det (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .cond_i (slip_cond),
        .trig_i (st.slip_irq_trigger),
        .hit_o  (slip_hit)
    );

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_st = st;
        if (reg_wr_i && reg_addr_i == TXIRQ_ENABLE_ADDR) begin
            next_st.xfer_done_irq_enable = reg_wdata_i[TXIRQ_XFER_EN_BIT];
            next_st.slip_irq_enable      = reg_wdata_i[TXIRQ_SLIP_EN_BIT];
        end
        if (reg_wr_i && reg_addr_i == TXIRQ_TRIGGER_ADDR) begin
            next_st.xfer_done_irq_trigger = txirq_trig_e'(
                reg_wdata_i[TXIRQ_XFER_TRIG_LSB +: 2]);
            next_st.slip_irq_trigger = txirq_trig_e'(
                reg_wdata_i[TXIRQ_SLIP_TRIG_LSB +: 2]);
        end
        // Reading status clears the flags; a hit in that same cycle wins.
        if (status_rd) begin
            next_st.xfer_done_flag = 1'b0;
            next_st.slip_flag      = 1'b0;
        end
        if (xfer_hit && st.xfer_done_irq_enable) begin
            next_st.xfer_done_flag = 1'b1;
        end
        if (slip_hit && st.slip_irq_enable) begin
            next_st.slip_flag = 1'b1;
        end
        next_st.summary = next_st.xfer_done_flag | next_st.slip_flag;
        next_st.irq_n   = ~next_st.summary;
        next_st.rdata   = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                TXIRQ_STATUS_ADDR: begin
                    next_st.rdata[TXIRQ_XFER_FLAG_BIT] = st.xfer_done_flag;
                    next_st.rdata[TXIRQ_SLIP_FLAG_BIT] = st.slip_flag;
                end
                TXIRQ_ENABLE_ADDR: begin
                    next_st.rdata[TXIRQ_XFER_EN_BIT] =
                        st.xfer_done_irq_enable;
                    next_st.rdata[TXIRQ_SLIP_EN_BIT] = st.slip_irq_enable;
                end
                TXIRQ_TRIGGER_ADDR: begin
                    next_st.rdata[TXIRQ_XFER_TRIG_LSB +: 2] =
                        st.xfer_done_irq_trigger;
                    next_st.rdata[TXIRQ_SLIP_TRIG_LSB +: 2] =
                        st.slip_irq_trigger;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st                       <= '0;
            st.xfer_done_irq_enable  <= TXIRQ_ENABLE_RST[0];
            st.slip_irq_enable       <= TXIRQ_ENABLE_RST[1];
            st.xfer_done_irq_trigger <= txirq_trig_e'(TXIRQ_TRIGGER_RST);
            st.slip_irq_trigger      <= txirq_trig_e'(TXIRQ_TRIGGER_RST);
            st.irq_n                 <= 1'b1;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign reg_rdata_o      = st.rdata;
    assign irq_n_o          = st.irq_n;
    assign tx_summary_o     = st.summary;
    assign xfer_done_flag_o = st.xfer_done_flag;
    assign slip_flag_o      = st.slip_flag;

    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    chk_xfer_masked: assert property (
        (ce_i && !st.xfer_done_irq_enable && !st.xfer_done_flag)
        |=> !st.xfer_done_flag)
        else $error("transfer flag set while masked");
    chk_slip_masked: assert property (
        (ce_i && !st.slip_irq_enable && !st.slip_flag) |=> !st.slip_flag)
        else $error("slip flag set while masked");
    chk_enable_readback: assert property (
        (ce_i && reg_rd_i && reg_addr_i == TXIRQ_ENABLE_ADDR)
        |=> reg_rdata_o == {6'h00, $past(st.slip_irq_enable),
                            $past(st.xfer_done_irq_enable)})
        else $error("enable register readback wrong");
    chk_trigger_readback: assert property (
        (ce_i && reg_rd_i && reg_addr_i == TXIRQ_TRIGGER_ADDR)
        |=> reg_rdata_o[7:4] == 4'h0)
        else $error("trigger register upper bits not zero");
    chk_level_sets: assert property (
        (ce_i && st.xfer_done_irq_trigger == TRIG_LEVEL && xfer_cond
         && st.xfer_done_irq_enable) |=> st.xfer_done_flag ##1 1'b1)
        else $error("level mode did not set transfer flag");
    chk_copy_gated: assert property (
        (ce_i && transmit_copy_disable_i && !st.xfer_done_flag)
        |=> !st.xfer_done_flag)
        else $error("transfer flag set while copies disabled");
    chk_irq_tracks: assert property (
        (st.xfer_done_flag && !irq_n_o && tx_summary_o)
        or !st.xfer_done_flag)
        else $error("interrupt output not asserted with flag");
    chk_slip_sets: assert property (
        (ce_i && slip_hit && st.slip_irq_enable) |=> st.slip_flag)
        else $error("slip hit did not set slip flag");
    chk_set_wins: assert property (
        (ce_i && xfer_hit && st.xfer_done_irq_enable && status_rd)
        |=> st.xfer_done_flag)
        else $error("clear beat a simultaneous set");
    chk_freeze: assert property (
        !ce_i |=> $stable(st))
        else $error("state moved while clock enable low");
    chk_read_clears: assert property (
        (ce_i && status_rd && !xfer_hit && !slip_hit)
        |=> !st.xfer_done_flag && !st.slip_flag)
        else $error("status read did not clear the flags");
    chk_status_readback: assert property (
        (ce_i && status_rd)
        |=> reg_rdata_o == {6'h00, $past(st.slip_flag),
                            $past(st.xfer_done_flag)})
        else $error("status readback wrong");

    cov_xfer_irq: cover property (
        ce_i && xfer_hit && st.xfer_done_irq_enable ##1 !irq_n_o);
    cov_slip_block: cover property (
        ce_i && slip_source_select_i && slip_hit && st.slip_irq_enable);
    cov_clear: cover property (
        st.xfer_done_flag && status_rd && ce_i ##1 !st.xfer_done_flag);
    cov_freeze: cover property (
        !ce_i && (xfer_hit || slip_hit));
    cov_set_wins: cover property (
        ce_i && xfer_hit && st.xfer_done_irq_enable && status_rd);

endmodule // txirq_top

// ### verification/tb_transmitter_irq_mask_mode.sv
`timescale 1ns/1ps
module tb_transmitter_irq_mask_mode;
    import txirq_pkg::*;
    logic       mclk_i    = 1'b0;
    logic       rst_i     = 1'b1;
    logic       ce_i      = 1'b1;
    logic       xe        = 1'b0;
    logic       dis       = 1'b0;
    logic       as        = 1'b0;
    logic       bs        = 1'b0;
    logic       sel       = 1'b0;
    logic [7:0] addr, wdata, rdata, d;
    logic       wr, rd, irq_n, summ, xf, sf;
    logic       ex, es, px, ps, enx, ens;
    logic [1:0] mx, ms;
    int         error_cnt = 0;
    int         checks    = 0;

    always #4 mclk_i = ~mclk_i;

    txirq_host host_u (.mclk_i(mclk_i), .reg_rdata_i(rdata),
        .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd));

    txirq_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .xfer_complete_event_i(xe),
        .transmit_copy_disable_i(dis), .async_slip_i(as),
        .block_start_i(bs), .slip_source_select_i(sel), .irq_n_o(irq_n),
        .tx_summary_o(summ), .xfer_done_flag_o(xf), .slip_flag_o(sf));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] s,
                       input logic [7:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    function automatic logic fire(input logic [1:0] m, input logic p,
                                  input logic c);
        case (m)
            2'h0: return c & ~p;
            2'h1: return ~c & p;
            2'h2: return c;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic rb();
        return 1'($urandom_range(0, 1));
    endfunction

    // Disable and select only change while all sources are low, so the
    // expected history does not depend on where the gate sits.
    task automatic step(input logic x, input logic a, input logic b,
                        input logic c);
        logic       cx, cs;
        logic [7:0] ef;
        xe   = x;
        as   = a;
        bs   = b;
        ce_i = c;
        @(negedge mclk_i);
        cx = x & ~dis;
        cs = sel ? b : a;
        // A frozen cycle keeps both the flags and the source history.
        if (c) begin
            ex = ex | (enx & fire(mx, px, cx));
            es = es | (ens & fire(ms, ps, cs));
            px = cx;
            ps = cs;
        end
        ef = {4'h0, ~(ex | es), ex | es, es, ex};
        chk("flags", {4'h0, irq_n, summ, sf, xf}, ef);
    endtask

    task automatic clr();
        step(1'b0, 1'b0, 1'b0, 1'b1);
        host_u.rd(8'h0a, d);
        chk("status", d, {6'h0, es, ex});
        chk("rdata_idle", rdata, 8'h00);
        ex = 1'b0;
        es = 1'b0;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hb11b));
        {ex, es, px, ps, enx, ens, mx, ms} = '0;
        repeat (5) @(negedge mclk_i);
        rst_i = 1'b0;
        host_u.rd(8'h0b, d);
        chk("enable_rst", d, 8'h00);
        host_u.rd(8'h0c, d);
        chk("trigger_rst", d, 8'h00);
        host_u.wr(8'h0b, 8'hff);
        host_u.wr(8'h0c, 8'hff);
        host_u.wr(8'h20, 8'h5a);
        host_u.wr(8'h0a, 8'hff);
        host_u.rd(8'h0b, d);
        chk("enable_rb", d, 8'h03);
        host_u.rd(8'h0c, d);
        chk("trigger_rb", d, 8'h0f);
        host_u.rd(8'h20, d);
        chk("unmapped", d, 8'h00);
        host_u.rd(8'h0a, d);
        chk("status_ro", d, 8'h00);
        $display("test 0 done");
        // Level mode with the source held high: a status read in the cycle
        // of a hit must leave the flag set; then a mid-run reset.
        host_u.wr(8'h0b, 8'h01);
        host_u.wr(8'h0c, 8'h02);
        xe = 1'b1;
        @(negedge mclk_i);
        chk("level_set", {6'h0, irq_n, xf}, 8'h01);
        host_u.rd(8'h0a, d);
        chk("set_wins_rd", d, 8'h01);
        chk("set_wins", {6'h0, irq_n, xf}, 8'h01);
        xe = 1'b0;
        host_u.rd(8'h0a, d);
        chk("clear_rd", d, 8'h01);
        chk("cleared", {6'h0, irq_n, xf}, 8'h02);
        xe = 1'b1;
        @(negedge mclk_i);
        chk("pre_rst", {7'h0, xf}, 8'h01);
        rst_i = 1'b1;
        xe    = 1'b0;
        repeat (2) @(negedge mclk_i);
        rst_i = 1'b0;
        chk("rst_flags", {4'h0, irq_n, summ, sf, xf}, 8'h08);
        host_u.rd(8'h0b, d);
        chk("enable_rst2", d, 8'h00);
        host_u.rd(8'h0c, d);
        chk("trigger_rst2", d, 8'h00);
        $display("test 1 done");
        // Every mode, reserved code included, with each mask state.
        for (int t = 0; t < 16; t++) begin
            enx = t[0] & ~t[3];
            ens = t[0] & t[3];
            mx  = t[2:1];
            ms  = t[2:1];
            dis = ($urandom_range(0, 3) == 0);
            sel = rb();
            clr();
            host_u.wr(8'h0b, {6'h0, ens, enx});
            host_u.wr(8'h0c, {4'h0, ms, mx});
            repeat (12) step(rb(), rb(), rb(), $urandom_range(0, 3) != 0);
            clr();
            $display("test %0d done", t + 2);
        end
        end_sim();
    end

    // Runs take well under a thousand cycles; this bounds a hang.
    initial begin
        repeat (3000) @(posedge mclk_i);
        error_cnt++;
        end_sim();
    end
endmodule // tb_transmitter_irq_mask_mode

// ### verification/txirq_host.sv
`timescale 1ns/1ps
module txirq_host (
    // Clock and read data.
    input  wire logic       mclk_i,
    input  wire logic [7:0] reg_rdata_i,
    // Register port requests.
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o
);
    // Strobes start low so nothing is requested while reset is held.
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Both tasks are entered at a falling edge, hold one strobe cycle and
    // then leave one idle cycle, so a second call never raises a strobe in
    // the time step that lowered it.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(negedge mclk_i);
        reg_wr_o    = 1'b0;
        @(negedge mclk_i);
    endtask
    // Read data stands one cycle only, so it is taken at the next fall.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(negedge mclk_i);
        reg_rd_o   = 1'b0;
        d          = reg_rdata_i;
        @(negedge mclk_i);
    endtask
endmodule // txirq_host
